// [hdl/cds_pkg.sv]
// shared constants of the card dma cycle sequencer
package cds_pkg;
    // ***********************************************
    // register offsets
    // ***********************************************
    localparam logic [7:0] OFS_SETUP0 = 8'h3a;
    localparam logic [7:0] OFS_CMD0 = 8'h3b;
    localparam logic [7:0] OFS_RECOV0 = 8'h3c;
    localparam logic [7:0] OFS_SETUP1 = 8'h3d;
    localparam logic [7:0] OFS_CMD1 = 8'h3e;
    localparam logic [7:0] OFS_RECOV1 = 8'h3f;
    localparam logic [7:0] OFS_CTRL = 8'h40;
    localparam logic [7:0] OFS_PRESCALE = 8'h41;
    localparam logic [7:0] OFS_STATUS = 8'h42;

    // ***********************************************
    // reset values and fields
    // ***********************************************
    localparam logic [7:0] RST_SETUP0 = 8'h01;
    localparam logic [7:0] RST_CMD0 = 8'h06;
    localparam logic [7:0] RST_RECOV0 = 8'h03;
    localparam logic [7:0] RST_SET1 = 8'h00;
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [7:0] RST_PRESCALE = 8'h01;
    localparam int CTRL_ENABLE = 0;
    localparam int CTRL_SET_SEL = 1;
    localparam int STAT_BUSY = 0;
    localparam int STAT_REQ = 1;
    localparam int STAT_TC = 2;
    localparam int STAT_WAITED = 3;

    // ***********************************************
    // timing
    // ***********************************************
    localparam int CLK_NS = 25;
    localparam int TCP_NS = 40;
    localparam int REQ_DELAY_NS = 40;
    localparam int REQ_DELAY_CYC = (REQ_DELAY_NS + CLK_NS - 1) / CLK_NS;
    localparam int WAIT_REL_NS = 2 * TCP_NS;
    localparam int WAIT_REL_CYC = (WAIT_REL_NS + CLK_NS - 1) / CLK_NS;
    localparam int TC_LEAD_MAX_NS = 50;
    localparam int TC_LEAD_CYC = TC_LEAD_MAX_NS / CLK_NS;
    localparam int SYS_TC_NS = 40;
    localparam int SYS_TC_CYC = (SYS_TC_NS + CLK_NS - 1) / CLK_NS;
endpackage

// [hdl/cds_phase_timer.sv]
// phase down-counter loaded from prescale and timer value
`timescale 1ns/1ps
module cds_phase_timer (
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // control
    input wire logic load,
    input wire logic [7:0] timer_count_value,
    input wire logic [7:0] timer_prescale,
    // status
    output logic done
);
    logic [16:0] tcp_units;
    logic [21:0] ns_total;
    logic [21:0] cycles;
    logic [21:0] cnt_reg;
    logic [21:0] cnt_next;

    // length in internal 40 ns units, then rounded up to core cycles
    assign tcp_units = 17'(timer_prescale * timer_count_value) + 17'h00001;
    assign ns_total = 22'(tcp_units * cds_pkg::TCP_NS);
    assign cycles = 22'((ns_total + 22'(cds_pkg::CLK_NS - 1)) / 22'(cds_pkg::CLK_NS));
    assign cnt_next = load ? cycles - 22'h000001 : (cnt_reg != 22'h000000 ? cnt_reg - 22'h000001 : cnt_reg);
    assign done = (cnt_reg == 22'h000000);

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            cnt_reg <= 22'h000000;
        end else begin
            cnt_reg <= cnt_next;
        end
    end
endmodule // cds_phase_timer

// [hdl/cds_req_gate.sv]
// request gating and acknowledge qualification delay
`timescale 1ns/1ps
module cds_req_gate (
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // inputs
    input wire logic enable,
    input wire logic card_req,
    input wire logic fifo_empty,
    input wire logic idle,
    input wire logic sys_dack_n,
    // outputs
    output logic sys_drq,
    output logic start
);
    logic [3:0] qual_reg;
    logic [3:0] qual_next;
    logic both_active;

    // no request reaches the system while card write data is still queued
    assign sys_drq = enable && card_req && fifo_empty && idle;
    assign both_active = sys_drq && !sys_dack_n;
    assign qual_next = !both_active ? 4'h0 : (qual_reg != 4'hf ? qual_reg + 4'h1 : qual_reg);
    // cycle begins only once request and acknowledge have both stood long enough
    assign start = both_active && (qual_reg >= 4'(cds_pkg::REQ_DELAY_CYC - 1));

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            qual_reg <= 4'h0;
        end else begin
            qual_reg <= qual_next;
        end
    end
endmodule // cds_req_gate

// [hdl/cds_top.sv]
// card dma cycle sequencer: registers, phase machine and card strobes
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
// Functional notes
// - cycle starts 40 ns after request and acknowledge
// - read cycle: write strobe commands, controls preset
// - setup length is prescale times value plus one
// - command width computed the same way
// - recovery phase follows command release
// - wait stretches command, release four clocks (two 40 ns units) later
// - system terminal count sampled early in command
// - read: card tc on write enable, nested
// - write: read strobe commands, tc on output enable
// - write data held until read strobe release
// - request withheld until write fifo drained
// - phase counts in 40 ns internal units
module cds_top (
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // system side
    output logic sys_drq,
    input wire logic sys_dack_n,
    input wire logic sys_tc,
    input wire logic dma_write,
    input wire logic [15:0] sys_wdata,
    output logic [15:0] sys_rdata,
    output logic cycle_done,
    // socket side
    input wire logic card_req,
    input wire logic fifo_empty,
    output logic [1:0] card_ce_n,
    output logic card_reg_n,
    output logic card_iord_n,
    output logic card_iowr_n,
    output logic card_oe_n,
    output logic card_we_n,
    input wire logic card_wait_n,
    input wire logic [15:0] card_data_i,
    output logic [15:0] card_data_o,
    output logic card_data_oe
);
    // ***********************************************
    // types and declarations
    // ***********************************************
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SETUP,
        ST_CMD,
        ST_RECOV,
        ST_RELEASE
    } cds_state_t;

    cds_state_t state_reg;
    cds_state_t state_next;

    logic [7:0] setup0_reg;
    logic [7:0] cmd0_reg;
    logic [7:0] recov0_reg;
    logic [7:0] setup1_reg;
    logic [7:0] cmd1_reg;
    logic [7:0] recov1_reg;
    logic [7:0] ctrl_reg;
    logic [7:0] prescale_reg;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic write_cyc_reg;
    logic tc_latched_reg;
    logic tc_latched_next;
    logic last_tc_reg;
    logic waited_reg;
    logic waited_next;
    logic [3:0] hold_reg;
    logic [3:0] hold_next;
    logic [7:0] elapsed_reg;
    logic [7:0] elapsed_next;
    logic [15:0] wdata_reg;
    logic [15:0] sys_rdata_reg;
    logic cycle_done_reg;

    wire set_sel = ctrl_reg[cds_pkg::CTRL_SET_SEL];
    wire enable = ctrl_reg[cds_pkg::CTRL_ENABLE];
    wire [7:0] setup_val = set_sel ? setup1_reg : setup0_reg;
    wire [7:0] cmd_val = set_sel ? cmd1_reg : cmd0_reg;
    wire [7:0] recov_val = set_sel ? recov1_reg : recov0_reg;

    wire start;
    wire setup_done;
    wire cmd_done;
    wire recov_done;
    wire idle = (state_reg == ST_IDLE);
    wire in_cmd = (state_reg == ST_CMD);
    wire in_cycle = !idle && (state_reg != ST_RELEASE);
    wire wait_active = !card_wait_n;

    // ***********************************************
    // register decode
    // ***********************************************
    wire wr_setup0 = reg_wr && (reg_addr == cds_pkg::OFS_SETUP0);
    wire wr_cmd0 = reg_wr && (reg_addr == cds_pkg::OFS_CMD0);
    wire wr_recov0 = reg_wr && (reg_addr == cds_pkg::OFS_RECOV0);
    wire wr_setup1 = reg_wr && (reg_addr == cds_pkg::OFS_SETUP1);
    wire wr_cmd1 = reg_wr && (reg_addr == cds_pkg::OFS_CMD1);
    wire wr_recov1 = reg_wr && (reg_addr == cds_pkg::OFS_RECOV1);
    wire wr_ctrl = reg_wr && (reg_addr == cds_pkg::OFS_CTRL);
    wire wr_prescale = reg_wr && (reg_addr == cds_pkg::OFS_PRESCALE);

    wire [7:0] status_val = {4'h0, waited_reg, last_tc_reg, sys_drq, !idle};

    always_comb begin
        case (reg_addr)
            cds_pkg::OFS_SETUP0: rdata_next = setup0_reg;
            cds_pkg::OFS_CMD0: rdata_next = cmd0_reg;
            cds_pkg::OFS_RECOV0: rdata_next = recov0_reg;
            cds_pkg::OFS_SETUP1: rdata_next = setup1_reg;
            cds_pkg::OFS_CMD1: rdata_next = cmd1_reg;
            cds_pkg::OFS_RECOV1: rdata_next = recov1_reg;
            cds_pkg::OFS_CTRL: rdata_next = ctrl_reg;
            cds_pkg::OFS_PRESCALE: rdata_next = prescale_reg;
            cds_pkg::OFS_STATUS: rdata_next = status_val;
            default: rdata_next = 8'h00;
        endcase
    end

    // read data only stands in the cycle after the strobe
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= reg_rd ? rdata_next : 8'h00;
        end
    end

    // ***********************************************
    // timing, control and prescale registers
    // ***********************************************
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            setup0_reg <= cds_pkg::RST_SETUP0;
            cmd0_reg <= cds_pkg::RST_CMD0;
            recov0_reg <= cds_pkg::RST_RECOV0;
            setup1_reg <= cds_pkg::RST_SET1;
            cmd1_reg <= cds_pkg::RST_SET1;
            recov1_reg <= cds_pkg::RST_SET1;
            ctrl_reg <= cds_pkg::RST_CTRL;
            prescale_reg <= cds_pkg::RST_PRESCALE;
        end else begin
            if (wr_setup0) begin
                setup0_reg <= reg_wdata;
            end
            if (wr_cmd0) begin
                cmd0_reg <= reg_wdata;
            end
            if (wr_recov0) begin
                recov0_reg <= reg_wdata;
            end
            if (wr_setup1) begin
                setup1_reg <= reg_wdata;
            end
            if (wr_cmd1) begin
                cmd1_reg <= reg_wdata;
            end
            if (wr_recov1) begin
                recov1_reg <= reg_wdata;
            end
            if (wr_ctrl) begin
                ctrl_reg <= {6'h00, reg_wdata[1:0]};
            end
            if (wr_prescale) begin
                prescale_reg <= reg_wdata;
            end
        end
    end

    // ***********************************************
    // request gate and phase timers
    // ***********************************************
    cds_req_gate u_req (
        .core_clk(core_clk),
        .nrst(nrst),
        .enable(enable),
        .card_req(card_req),
        .fifo_empty(fifo_empty),
        .idle(idle),
        .sys_dack_n(sys_dack_n),
        .sys_drq(sys_drq),
        .start(start)
    );

    // each timer is loaded in the cycle that enters its phase
    wire load_setup = idle && start;
    wire load_cmd = (state_reg == ST_SETUP) && setup_done;
    wire load_recov;

    cds_phase_timer u_setup (
        .core_clk(core_clk),
        .nrst(nrst),
        .load(load_setup),
        .timer_count_value(setup_val),
        .timer_prescale(prescale_reg),
        .done(setup_done)
    );

    cds_phase_timer u_cmd (
        .core_clk(core_clk),
        .nrst(nrst),
        .load(load_cmd),
        .timer_count_value(cmd_val),
        .timer_prescale(prescale_reg),
        .done(cmd_done)
    );

    cds_phase_timer u_recov (
        .core_clk(core_clk),
        .nrst(nrst),
        .load(load_recov),
        .timer_count_value(recov_val),
        .timer_prescale(prescale_reg),
        .done(recov_done)
    );

    // ***********************************************
    // wait handling and command end
    // ***********************************************
    // the card is trusted to raise wait early enough; late wait still stretches
    // the strobe if it lands in or before the end cycle
    wire end_cmd = in_cmd && cmd_done && !wait_active && (hold_reg == 4'h0);
    assign load_recov = end_cmd;

    always_comb begin
        hold_next = hold_reg;
        if (!in_cmd) begin
            hold_next = 4'h0;
        end else if (wait_active) begin
            hold_next = 4'(cds_pkg::WAIT_REL_CYC);
        end else if (hold_reg != 4'h0) begin
            hold_next = hold_reg - 4'h1;
        end
    end

    assign waited_next = load_setup ? 1'b0 : (waited_reg || (in_cmd && wait_active));
    assign elapsed_next = load_cmd ? 8'h00 : ((in_cmd && elapsed_reg != 8'hff) ? elapsed_reg + 8'h01 : elapsed_reg);

    // system tc is valid by the second command cycle and is caught there
    wire tc_sample = in_cmd && (elapsed_reg == 8'(cds_pkg::SYS_TC_CYC - 1));
    assign tc_latched_next = load_cmd ? 1'b0 : (tc_sample ? sys_tc : tc_latched_reg);

    // ***********************************************
    // phase machine
    // ***********************************************
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (start) begin
                    state_next = ST_SETUP;
                end
            end
            ST_SETUP: begin
                if (setup_done) begin
                    state_next = ST_CMD;
                end
            end
            ST_CMD: begin
                if (end_cmd) begin
                    state_next = ST_RECOV;
                end
            end
            ST_RECOV: begin
                if (recov_done) begin
                    state_next = ST_RELEASE;
                end
            end
            ST_RELEASE: begin
                // a held acknowledge never starts a second cycle
                if (sys_dack_n) begin
                    state_next = ST_IDLE;
                end
            end
            default: state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            state_reg <= ST_IDLE;
            hold_reg <= 4'h0;
            elapsed_reg <= 8'h00;
            waited_reg <= 1'b0;
            tc_latched_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            hold_reg <= hold_next;
            elapsed_reg <= elapsed_next;
            waited_reg <= waited_next;
            tc_latched_reg <= tc_latched_next;
        end
    end

    // ***********************************************
    // data path and cycle record
    // ***********************************************
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            write_cyc_reg <= 1'b0;
            wdata_reg <= 16'h0000;
            sys_rdata_reg <= 16'h0000;
            last_tc_reg <= 1'b0;
            cycle_done_reg <= 1'b0;
        end else begin
            cycle_done_reg <= (state_reg == ST_RECOV) && recov_done;
            if (load_setup) begin
                write_cyc_reg <= dma_write;
                wdata_reg <= sys_wdata;
            end
            // card data is taken in the last command cycle, after output enable has risen and before the read strobe rises
            if (end_cmd && write_cyc_reg) begin
                sys_rdata_reg <= card_data_i;
            end
            if (end_cmd) begin
                last_tc_reg <= tc_latched_reg;
            end
        end
    end

    // ***********************************************
    // card strobes
    // ***********************************************
    // tc window: from the lead point until one cycle before strobe release
    wire tc_window = in_cmd && tc_latched_reg && !end_cmd
        && (elapsed_reg >= 8'(cds_pkg::TC_LEAD_CYC));
    wire read_cmd = in_cmd && !write_cyc_reg;
    wire write_cmd = in_cmd && write_cyc_reg;

    assign card_ce_n = in_cycle ? 2'b00 : 2'b11;
    assign card_reg_n = !in_cycle;
    assign card_iowr_n = !read_cmd;
    assign card_iord_n = !write_cmd;
    assign card_we_n = !(tc_window && !write_cyc_reg);
    assign card_oe_n = !(tc_window && write_cyc_reg);
    // in read cycles only, data drives from setup through recovery so it is stable around the write strobe
    assign card_data_oe = in_cycle && !write_cyc_reg;
    assign card_data_o = wdata_reg;

    assign reg_rdata = rdata_reg;
    assign sys_rdata = sys_rdata_reg;
    assign cycle_done = cycle_done_reg;
endmodule // cds_top

// [verif/cds_chk.sv]
// concurrent checks on the sequencer's top-level ports
`timescale 1ns/1ps
module cds_chk (
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // system side
    input wire logic sys_drq,
    input wire logic sys_dack_n,
    input wire logic [15:0] sys_rdata,
    // socket side
    input wire logic card_req,
    input wire logic fifo_empty,
    input wire logic [1:0] card_ce_n,
    input wire logic card_iord_n,
    input wire logic card_iowr_n,
    input wire logic card_oe_n,
    input wire logic card_we_n,
    input wire logic card_wait_n,
    input wire logic [15:0] card_data_i,
    input wire logic card_data_oe
);
    default clocking dcb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);
    wire cmd_on = !(card_iowr_n && card_iord_n);
    wire ce_on = card_ce_n == 2'b00;
    wire ce_off = card_ce_n == 2'b11;
    // *****************************
    // properties
    // *****************************
    sequence s_qualified;
        $past(sys_drq && !sys_dack_n, 2) && $past(!sys_dack_n);
    endsequence
    sequence s_wait_end;
        $rose(card_wait_n) && cmd_on;
    endsequence
    property p_start;
        $fell(card_ce_n[0]) |-> s_qualified;
    endproperty
    property p_read_cmd;
        !card_iowr_n |-> card_iord_n && card_oe_n && card_data_oe;
    endproperty
    property p_setup;
        $rose(cmd_on) |-> $past(ce_on) && $past(ce_on, 2);
    endproperty
    property p_cmd_min;
        $rose(cmd_on) |-> cmd_on [*2];
    endproperty
    property p_recov;
        $fell(cmd_on) |-> ce_on [*2];
    endproperty
    property p_wait_hold;
        !card_wait_n && cmd_on |=> cmd_on;
    endproperty
    property p_wait_release;
        s_wait_end |-> cmd_on [*4];
    endproperty
    property p_we_nest;
        $fell(card_we_n) |-> $past(!card_iowr_n, 2) && $past(card_iowr_n, 3);
    endproperty
    property p_oe_nest;
        !card_oe_n |-> !card_iord_n ##1 !card_iord_n;
    endproperty
    property p_wdata;
        $rose(card_iord_n) |-> sys_rdata == $past(card_data_i);
    endproperty
    property p_drq_gate;
        sys_drq |-> card_req && fifo_empty && ce_off;
    endproperty
    a_start: assert property (p_start) else $error("cycle began without acknowledge");
    a_read_cmd: assert property (p_read_cmd) else $error("read command setup bad");
    a_setup: assert property (p_setup) else $error("setup too short");
    a_cmd_min: assert property (p_cmd_min) else $error("command too short");
    a_recov: assert property (p_recov) else $error("recovery too short");
    a_wait_hold: assert property (p_wait_hold) else $error("command ended in wait");
    a_wait_release: assert property (p_wait_release) else $error("wait hold short");
    a_we_nest: assert property (p_we_nest) else $error("card tc start off");
    a_oe_nest: assert property (p_oe_nest) else $error("card tc not nested");
    a_wdata: assert property (p_wdata) else $error("write data not held");
    a_drq_gate: assert property (p_drq_gate) else $error("request not withheld");
endmodule // cds_chk

bind cds_top cds_chk i_cds_chk (
    .core_clk(core_clk), .nrst(nrst), .sys_drq(sys_drq), .sys_dack_n(sys_dack_n),
    .sys_rdata(sys_rdata), .card_req(card_req), .fifo_empty(fifo_empty),
    .card_ce_n(card_ce_n), .card_iord_n(card_iord_n), .card_iowr_n(card_iowr_n),
    .card_oe_n(card_oe_n), .card_we_n(card_we_n), .card_wait_n(card_wait_n),
    .card_data_i(card_data_i), .card_data_oe(card_data_oe)
);

// [verif/cds_far_model.sv]
// far side model: host acknowledge and socket card
`timescale 1ns/1ps
module cds_far_model (
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // device side
    input wire logic sys_drq,
    input wire logic cycle_done,
    input wire logic card_iord_n,
    input wire logic card_iowr_n,
    input wire logic [15:0] card_data_o,
    input wire logic card_data_oe,
    // bench control
    input wire logic [7:0] wait_len,
    input wire logic [15:0] card_word,
    // driven
    output logic sys_dack_n,
    output logic card_wait_n,
    output logic [15:0] card_data_i
);
    logic [7:0] cmd_cnt;
    wire cmd_on = !(card_iord_n && card_iowr_n);
    // card drives only under the read strobe; an undriven bus shows inverted data
    assign card_data_i = card_data_oe ? card_data_o : (card_iord_n ? ~card_word : card_word);
    // wait drops in the second command cycle, inside c minus two
    assign card_wait_n = !(cmd_on && cmd_cnt >= 8'h01 && cmd_cnt <= wait_len);
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            sys_dack_n <= 1'b1;
            cmd_cnt <= 8'h00;
        end else begin
            cmd_cnt <= cmd_on ? cmd_cnt + 8'h01 : 8'h00;
            // acknowledge a cycle after the request, release at cycle end
            if (cycle_done) begin
                sys_dack_n <= 1'b1;
            end else if (sys_drq) begin
                sys_dack_n <= 1'b0;
            end
        end
    end
endmodule // cds_far_model

// [verif/cds_top_tb_top.sv]
// self-checking bench for the card dma cycle sequencer
`timescale 1ns/1ps
`define CHK(g, e) check_eq(32'(g), 32'(e))
module cds_top_tb_top;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, wait_len = 8'h00;
    logic reg_wr = 1'b0, reg_rd = 1'b0, sys_tc = 1'b0, dma_write = 1'b0;
    logic card_req = 1'b0, fifo_empty = 1'b1, sys_drq, sys_dack_n, cycle_done;
    logic [15:0] sys_wdata = 16'h0000, card_word = 16'h0000, sys_rdata, card_data_i, card_data_o;
    logic [1:0] card_ce_n;
    logic card_reg_n, card_iord_n, card_iowr_n, card_oe_n, card_we_n, card_wait_n, card_data_oe;
    int mismatches = 0, checks = 0;
    always #12.5 core_clk = ~core_clk;
    cds_top i_cds_top (.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .sys_drq(sys_drq), .sys_dack_n(sys_dack_n), .sys_tc(sys_tc), .dma_write(dma_write),
        .sys_wdata(sys_wdata), .sys_rdata(sys_rdata), .cycle_done(cycle_done),
        .card_req(card_req), .fifo_empty(fifo_empty), .card_ce_n(card_ce_n),
        .card_reg_n(card_reg_n), .card_iord_n(card_iord_n), .card_iowr_n(card_iowr_n),
        .card_oe_n(card_oe_n), .card_we_n(card_we_n), .card_wait_n(card_wait_n),
        .card_data_i(card_data_i), .card_data_o(card_data_o), .card_data_oe(card_data_oe));
    cds_far_model i_cds_far_model (.core_clk(core_clk), .nrst(nrst), .sys_drq(sys_drq),
        .cycle_done(cycle_done), .card_iord_n(card_iord_n), .card_iowr_n(card_iowr_n),
        .card_data_o(card_data_o), .card_data_oe(card_data_oe), .wait_len(wait_len),
        .card_word(card_word), .sys_dack_n(sys_dack_n), .card_wait_n(card_wait_n),
        .card_data_i(card_data_i));
    // *****************************
    // tasks
    // *****************************
    task automatic finish_test;
        $display("checks=%0d mismatches=%0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic check_eq(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // cycles per phase, 40 ns units rounded up to whole core cycles
    function automatic int ph(input int p, input int v);
        return ((p * v + 1) * cds_pkg::TCP_NS + cds_pkg::CLK_NS - 1) / cds_pkg::CLK_NS;
    endfunction
    // an idle cycle follows each access so no strobe is set twice in a step
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic reg_check(input logic [7:0] a, input logic [7:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(posedge core_clk);
        `CHK(reg_rdata, e);
    endtask
    task automatic run_cycle(input logic wr, input logic tc, input logic [7:0] wl,
                             input int s, input int c, input int r);
        int sc, cc, rc, tcl, bad, n;
        logic [15:0] wd;
        sc = 0;
        cc = 0;
        rc = 0;
        tcl = 0;
        bad = 0;
        n = 0;
        wd = 16'($urandom);
        dma_write <= wr;
        sys_tc <= tc;
        sys_wdata <= wd;
        card_word <= ~wd;
        wait_len <= wl;
        card_req <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
            if (card_ce_n === 2'b00) begin
                if ((wr ? card_iord_n : card_iowr_n) === 1'b0) cc++;
                else if (cc == 0) sc++;
                else rc++;
            end
            if ((wr ? card_oe_n : card_we_n) === 1'b0) tcl++;
            if ((wr ? card_iowr_n & card_we_n : card_iord_n & card_oe_n) !== 1'b1) bad++;
            if (!wr && card_iowr_n === 1'b0 && card_data_o !== wd) bad++;
            if (card_reg_n !== card_ce_n[0]) bad++;
        end while (cycle_done !== 1'b1 && n < 400);
        card_req <= 1'b0;
        `CHK(n < 400, 1);
        `CHK(sc, s);
        if (wl == 0) `CHK(cc, c);
        else `CHK(cc >= c, 1);
        `CHK(rc, r);
        `CHK(tcl, tc ? cc - 3 : 0);
        `CHK(bad, 0);
        if (wr) `CHK(sys_rdata, card_word);
        repeat (4) @(posedge core_clk);
        `CHK(card_ce_n, 2'b11);
    endtask
    // *****************************
    // tests
    // *****************************
    initial begin
        #(25 * 40000);
        mismatches++;
        finish_test();
    end
    initial begin
        int p, sv, cv, rv;
        void'($urandom(32'ha150));
        repeat (8) @(posedge core_clk);
        nrst <= 1'b1;
        @(posedge core_clk);
        reg_check(cds_pkg::OFS_SETUP0, cds_pkg::RST_SETUP0);
        reg_check(cds_pkg::OFS_CMD0, cds_pkg::RST_CMD0);
        reg_check(cds_pkg::OFS_RECOV0, cds_pkg::RST_RECOV0);
        for (int i = 0; i < 3; i++) reg_check(cds_pkg::OFS_SETUP1 + 8'(i), cds_pkg::RST_SET1);
        reg_check(cds_pkg::OFS_PRESCALE, cds_pkg::RST_PRESCALE);
        reg_check(8'h10, 8'h00);
        reg_write(cds_pkg::OFS_STATUS, 8'hff);
        reg_check(cds_pkg::OFS_STATUS, 8'h00);
        reg_write(cds_pkg::OFS_CTRL, 8'h01);
        fifo_empty <= 1'b0;
        card_req <= 1'b1;
        repeat (6) @(posedge core_clk);
        `CHK(sys_drq, 1'b0);
        `CHK(card_ce_n, 2'b11);
        fifo_empty <= 1'b1;
        run_cycle(1'b0, 1'b1, 8'h00, ph(1, 1), ph(1, 6), ph(1, 3));
        run_cycle(1'b1, 1'b1, 8'h00, ph(1, 1), ph(1, 6), ph(1, 3));
        run_cycle(1'b0, 1'b0, 8'h00, ph(1, 1), ph(1, 6), ph(1, 3));
        // wait low over command cycles 1..10, then at least two 40 ns units more
        run_cycle(1'b0, 1'b1, 8'd10, ph(1, 1), 15, ph(1, 3));
        reg_check(cds_pkg::OFS_STATUS, 8'((1 << cds_pkg::STAT_TC) | (1 << cds_pkg::STAT_WAITED)));
        for (int k = 0; k < 5; k++) begin
            p = 1 + $urandom % 3;
            sv = $urandom % 4;
            cv = 3 + $urandom % 5;
            rv = $urandom % 4;
            reg_write(cds_pkg::OFS_PRESCALE, 8'(p));
            reg_write(cds_pkg::OFS_SETUP1, 8'(sv));
            reg_write(cds_pkg::OFS_CMD1, 8'(cv));
            reg_write(cds_pkg::OFS_RECOV1, 8'(rv));
            reg_check(cds_pkg::OFS_CMD1, 8'(cv));
            reg_write(cds_pkg::OFS_CTRL, 8'h03);
            run_cycle(1'($urandom), 1'($urandom), 8'h00, ph(p, sv), ph(p, cv), ph(p, rv));
        end
        // with the engine disabled a standing request must never reach the system
        reg_write(cds_pkg::OFS_CTRL, 8'h02);
        card_req <= 1'b1;
        repeat (4) @(posedge core_clk);
        `CHK(sys_drq, 1'b0);
        `CHK(card_ce_n, 2'b11);
        finish_test();
    end
endmodule // cds_top_tb_top
